// ==== bench/tpf_port_assertions.sv ====
// tpf_port_assertions: pin-level checks on the port top
`default_nettype none
module tpf_port_assertions
    import tpf_pkg::*;
#(parameter int unsigned DISCH_CNT = DISCH_CYC) (
    input wire logic       SYS_CLK_IN,
    input wire logic       RESET_IN,
    input wire logic       CABLE_UV_IN,
    input wire logic       SINK_TERM_IN,
    input wire logic       BMC_TX_ACTIVE_IN,
    input wire logic       BMC_TX_BIT_IN,
    input wire logic [1:0] CABLE_SWITCH_OUT,
    input wire logic [1:0] DIAG_CURRENT_OUT,
    input wire logic [1:0] DISCHARGE_OUT,
    input wire logic       ATTACHED_OUT,
    input wire logic       BMC_TX_OUT,
    input wire logic       BMC_TX_OE_OUT,
    input wire logic       ATTACH_BIAS_EN_OUT,
    input wire logic       ADC_RUN_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [19:0] dis_cnt_r;
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (RESET_IN);
    always_ff @(posedge SYS_CLK_IN) begin
        dis_cnt_r <= (|DISCHARGE_OUT) ? dis_cnt_r + 20'h1 : 20'h0;
    end
    sequence s_uv_hold; CABLE_UV_IN [*5]; endsequence
    sequence s_term_hold; SINK_TERM_IN [*4]; endsequence
    property p_uv; s_uv_hold |-> CABLE_SWITCH_OUT == 2'h0; endproperty
    property p_excl; $onehot0({CABLE_SWITCH_OUT, DIAG_CURRENT_OUT}); endproperty
    property p_dlen; $fell(|DISCHARGE_OUT) |-> dis_cnt_r == 20'(DISCH_CNT);
    endproperty
    property p_doff; |DISCHARGE_OUT |-> CABLE_SWITCH_OUT == 2'h0; endproperty
    property p_att; s_term_hold |-> ATTACHED_OUT; endproperty
    property p_tx; BMC_TX_ACTIVE_IN |=> BMC_TX_OE_OUT && !ATTACH_BIAS_EN_OUT
        && BMC_TX_OUT == $past(BMC_TX_BIT_IN); endproperty
    property p_hiz; !BMC_TX_ACTIVE_IN |=> !BMC_TX_OE_OUT && ATTACH_BIAS_EN_OUT;
    endproperty
    property p_adc; $fell(RESET_IN) |-> !ADC_RUN_OUT; endproperty
    a_uv: assert property (p_uv) else $error("switch on in uv");
    a_excl: assert property (p_excl) else $error("diag overlap");
    a_dlen: assert property (p_dlen) else $error("discharge length");
    a_doff: assert property (p_doff) else $error("discharge on");
    a_att: assert property (p_att) else $error("no attach");
    a_tx: assert property (p_tx) else $error("tx drive");
    a_hiz: assert property (p_hiz) else $error("tx not released");
    a_adc: assert property (p_adc) else $error("adc on at reset");
endmodule : tpf_port_assertions
`default_nettype wire

// ==== bench/tpf_port_top_tb.sv ====
// tpf_port_top_tb: self-checking bench for the port top
`default_nettype none
module tpf_port_top_tb import tpf_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rst = 1'b1, uv = 1'b0, term = 1'b0, sh = 1'b1;
    logic        tx_act = 1'b0, tx_bit = 1'b0;
    logic [9:0]  volt = 10'h000, pv;
    logic [6:0]  curr = 7'h00;
    logic        scl, m_sda, sda, sda_oe, adc_run, att, tx_oe, tx, bias;
    logic [1:0]  sw, diag, dis, rp, dis_seen = 2'h0;
    logic [15:0] v, obs, qe[$];
    string       qn[$];
    int          checks = 0, n_mismatch = 0;
    logic [31:0] rng = 32'hb0af412d;
    event        got;
    initial begin forever #20 clk = ~clk; end
    assign sda = m_sda & ~sda_oe;
    always @(posedge clk) if (|dis) dis_seen <= dis;
    tpf_tcpm_model tcpm (.clk_in(clk), .sda_in(sda), .scl_out(scl),
        .sda_out(m_sda));
    // short counts keep the run brief
    tpf_port_top #(.DIAG_CNT(20), .RETRY_CNT(60), .DISCH_CNT(16),
        .SAMPLE_CNT(30)) dut (.SYS_CLK_IN(clk), .RESET_IN(rst),
        .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE_OUT(sda_oe),
        .CABLE_UV_IN(uv), .ABOVE_SHORT_IN(sh), .SINK_TERM_IN(term),
        .ADC_VOLT_IN(volt), .ADC_CURR_IN(curr), .BMC_TX_ACTIVE_IN(tx_act),
        .BMC_TX_BIT_IN(tx_bit), .CABLE_SWITCH_OUT(sw), .DIAG_CURRENT_OUT(diag),
        .DISCHARGE_OUT(dis), .ATTACHED_OUT(att), .BMC_TX_OUT(tx),
        .BMC_TX_OE_OUT(tx_oe), .ATTACH_BIAS_EN_OUT(bias), .RP_ADV_OUT(rp),
        .ADC_RUN_OUT(adc_run));
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : rnd
    task automatic t(input string n, input logic [15:0] e, o);
        qn.push_back(n);
        qe.push_back(e);
        obs = o;
        -> got;
        #1;
    endtask : t
    task automatic chk(input string n, input logic [15:0] e, o);
        checks++;
        if (o !== e) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", n, e, o);
        end
    endtask : chk
    always @(got) chk(qn.pop_front(), qe.pop_front(), obs);
    task automatic fault(input logic [3:0] e, input logic hold);
        uv = 1'b1;
        repeat (6) @(negedge clk);
        t("fault", {12'h0, e}, {12'h0, sw, diag});
        if (!hold) begin
            uv = 1'b0;
            repeat (28) @(negedge clk);
            t("restart", 16'h1, {14'h0, sw});
        end
    endtask : fault
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    initial begin
        #2000000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        repeat (13) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        tcpm.rd(ADDR_POWER_CONFIG, v);
        t("pwr", {8'h0, RST_POWER_CONFIG}, v);
        t("run", 16'h0, {15'h0, adc_run});
        tcpm.wr(ADDR_POWER_CONFIG, 8'h00);
        volt = 10'(rnd());
        curr = 7'(rnd());
        repeat (150) @(negedge clk);
        tcpm.rd(ADDR_VOLT_LOW, v);
        t("volt", {6'h0, volt}, v);
        tcpm.rd(ADDR_CURRENT, v);
        t("curr", {9'h0, curr}, v);
        pv = volt;
        volt = ~volt;
        repeat (150) @(negedge clk);
        tcpm.rd(ADDR_VOLT_HIGH, v);
        t("held", {14'h0, pv[9:8]}, v);
        tcpm.wr(ADDR_POWER_CONFIG, 8'h40);
        pv = volt;
        volt = 10'(rnd());
        repeat (150) @(negedge clk);
        tcpm.rd(ADDR_VOLT_LOW, v);
        t("stop", {6'h0, pv}, v);
        $display("test adc done");
        term = 1'b1;
        sh = 1'b0;
        tcpm.wr(ADDR_CABLE_CTRL, 8'h01);
        repeat (30) @(negedge clk);
        t("stg", 16'h1, {12'h0, sw, diag});
        sh = 1'b1;
        repeat (30) @(negedge clk);
        fault(4'h1, 1'b0);
        fault(4'h1, 1'b0);
        fault(4'h0, 1'b1);
        tcpm.rd(ADDR_PORT_STATUS, v);
        t("flag", 16'h3, v);
        tcpm.wr(ADDR_FAULT_CONFIG, 8'h01);
        tcpm.rd(ADDR_PORT_STATUS, v);
        t("mask", 16'h2, v);
        uv = 1'b0;
        repeat (30) @(negedge clk);
        fault(4'h1, 1'b0);
        tcpm.wr(ADDR_FAULT_CONFIG, 8'h00);
        tcpm.rd(ADDR_PORT_STATUS, v);
        t("clr", 16'h6, v);
        fault(4'h1, 1'b0);
        fault(4'h1, 1'b0);
        $display("test fault done");
        for (int o = 0; o < 2; o++) begin
            tcpm.wr(ADDR_CABLE_CTRL, 8'(1 + 2 * o));
            repeat (30) @(negedge clk);
            t("chan", 16'(1 << o), {14'h0, sw});
            dis_seen = 2'h0;
            tcpm.wr(ADDR_CABLE_CTRL, 8'(2 * o));
            t("disch", 16'(1 << o), {14'h0, dis_seen});
        end
        for (int k = 0; k < 64; k++) begin
            {tx_act, tx_bit} = 2'(rnd());
            @(negedge clk);
        end
        tx_act = 1'b0;
        repeat (2) @(negedge clk);
        t("hiz", 16'h1, {14'h0, tx_oe, bias});
        tcpm.wr(ADDR_CABLE_CTRL, 8'h0c);
        t("rp", 16'h3, {14'h0, rp});
        t("ack", 16'h0, {15'h0, tcpm.nack_seen});
        $display("test pins done");
        end_of_test();
    end
endmodule : tpf_port_top_tb
bind tpf_port_top tpf_port_assertions #(.DISCH_CNT(DISCH_CNT)) u_chk (.*);
`default_nettype wire

// ==== bench/tpf_tcpm_model.sv ====
// tpf_tcpm_model: port manager acting as i2c controller
`default_nettype none
module tpf_tcpm_model
    import tpf_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic sda_in,
    output var logic  scl_out,
    output var logic  sda_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic nack_seen = 1'b0;
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // data moves one clock after scl falls, never beside the scl edge
    task automatic go(input logic b, output logic r);
        scl_out = 1'b0;
        @(negedge clk_in);
        sda_out = b;
        repeat (3) @(negedge clk_in);
        scl_out = 1'b1;
        repeat (4) @(negedge clk_in);
        r = sda_in;
    endtask : go
    task automatic cond(input logic a, input logic b);
        logic r;
        go(a, r);
        sda_out = b;
        repeat (4) @(negedge clk_in);
    endtask : cond
    task automatic xb(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) go(d[i], r);
        go(1'b1, r);
        nack_seen |= r;
    endtask : xb
    task automatic rb(input logic ak, output logic [7:0] q);
        logic r;
        for (int i = 7; i >= 0; i--) go(1'b1, q[i]);
        go(ak, r);
    endtask : rb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cond(1'b1, 1'b0);
        xb({RST_I2C_ADDR, 1'b0});
        xb(a);
        xb(d);
        cond(1'b0, 1'b1);
    endtask : wr
    // always one two-byte read, from the given address and the next
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        cond(1'b1, 1'b0);
        xb({RST_I2C_ADDR, 1'b0});
        xb(a);
        cond(1'b1, 1'b0);
        xb({RST_I2C_ADDR, 1'b1});
        rb(1'b0, v[7:0]);
        rb(1'b1, v[15:8]);
        cond(1'b0, 1'b1);
    endtask : rd
endmodule : tpf_tcpm_model
`default_nettype wire

// ==== src/tpf_i2c_target.sv ====
// tpf_i2c_target: oversampled i2c target turning bus bytes into reg accesses
`default_nettype none
module tpf_i2c_target
    import tpf_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = RST_I2C_ADDR
) (
    input  wire logic            clk_in,
    input  wire logic            rst_in,
    input  wire logic            scl_in,
    input  wire logic            sda_in,
    output logic                 sda_oe_out,
    input  wire logic [7:0]      rdata_in,
    output tpf_reg_req_type      req_out
);
    ////////////////////////////////////////////////////////////////////////
    logic [1:0]        scl_sync_r;
    logic [1:0]        sda_sync_r;
    logic              scl_d_r;
    logic              sda_d_r;
    tpf_i2c_state_type state_r;
    tpf_i2c_state_type next_r;
    logic [7:0]        shift_r;
    logic [3:0]        cnt_r;
    logic [7:0]        ptr_r;
    logic              drive_r;
    logic              wr_r;
    logic              rd_r;
    logic [7:0]        wdata_r;
    logic [7:0]        acc_addr_r;

    wire scl_s    = scl_sync_r[1];
    wire sda_s    = sda_sync_r[1];
    wire scl_rise = scl_s & ~scl_d_r;
    wire scl_fall = ~scl_s & scl_d_r;
    wire start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;
    wire byte_end = scl_fall & (cnt_r == 4'h8);
    wire addr_hit = (shift_r[7:1] == DEV_ADDR);

    assign sda_oe_out = drive_r;
    assign req_out    = '{wr: wr_r, rd: rd_r, addr: acc_addr_r,
                          wdata: wdata_r};

    // pins are foreign to this clock: two flops before any use
    always_ff @(posedge clk_in) begin
        scl_sync_r <= {scl_sync_r[0], scl_in};
        sda_sync_r <= {sda_sync_r[0], sda_in};
        scl_d_r    <= scl_s;
        sda_d_r    <= sda_s;
    end

    always_ff @(posedge clk_in) begin
        wr_r <= 1'b0;
        rd_r <= 1'b0;
        if (rst_in) begin
            state_r    <= I2_IDLE;
            next_r     <= I2_IDLE;
            shift_r    <= 8'h00;
            cnt_r      <= 4'h0;
            ptr_r      <= 8'h00;
            drive_r    <= 1'b0;
            wdata_r    <= 8'h00;
            acc_addr_r <= 8'h00;
        end else if (start_c) begin
            state_r <= I2_ADDR;
            cnt_r   <= 4'h0;
            drive_r <= 1'b0;
        end else if (stop_c) begin
            state_r <= I2_IDLE;
            drive_r <= 1'b0;
        end else begin
            case (state_r)
                I2_ADDR, I2_PTR, I2_WDATA: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], sda_s};
                        cnt_r   <= cnt_r + 4'h1;
                    end else if (byte_end) begin
                        drive_r <= 1'b1;
                        state_r <= I2_ACK;
                        if (state_r == I2_ADDR) begin
                            if (!addr_hit) begin
                                drive_r <= 1'b0;
                                state_r <= I2_IDLE;
                            end
                            next_r <= shift_r[0] ? I2_RDATA : I2_PTR;
                        end else if (state_r == I2_PTR) begin
                            ptr_r  <= shift_r;
                            next_r <= I2_WDATA;
                        end else begin
                            wr_r       <= 1'b1;
                            wdata_r    <= shift_r;
                            acc_addr_r <= ptr_r;
                            ptr_r      <= ptr_r + 8'h01;
                            next_r     <= I2_WDATA;
                        end
                    end
                end
                I2_ACK: begin
                    if (scl_fall) begin
                        drive_r <= 1'b0;
                        cnt_r   <= 4'h0;
                        state_r <= next_r;
                        if (next_r == I2_RDATA) begin
                            rd_r       <= 1'b1;
                            acc_addr_r <= ptr_r;
                            ptr_r      <= ptr_r + 8'h01;
                        end
                    end
                end
                I2_RDATA: begin
                    if (cnt_r == 4'h0) begin
                        // load a cycle late: mux follows the strobe address
                        shift_r <= rdata_in;
                        drive_r <= ~rdata_in[7];
                        cnt_r   <= 4'h1;
                    end else if (byte_end) begin
                        drive_r <= 1'b0;
                        state_r <= I2_MACK;
                    end else if (scl_fall) begin
                        drive_r <= ~shift_r[6];
                        shift_r <= {shift_r[6:0], 1'b0};
                        cnt_r   <= cnt_r + 4'h1;
                    end
                end
                I2_MACK: begin
                    if (scl_rise) begin
                        state_r <= sda_s ? I2_IDLE : I2_ACK;
                        next_r  <= I2_RDATA;
                    end
                end
                default: state_r <= I2_IDLE;
            endcase
        end
    end
endmodule : tpf_i2c_target
`default_nettype wire

// ==== src/tpf_pkg.sv ====
// tpf_pkg: shared constants and types for the port fault and bus adc block
`default_nettype none
package tpf_pkg;
    localparam int unsigned CLK_KHZ          = 25000;
    localparam int unsigned DIAG_TIME_US     = 500;
    localparam int unsigned RETRY_TIME_MS    = 16;
    localparam int unsigned DISCH_TIME_MS    = 1;
    localparam int unsigned SAMPLE_TIME_MS   = 1;
    // derived cycle counts (least times round up)
    localparam int unsigned DIAG_CYC   = (DIAG_TIME_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned RETRY_CYC  = RETRY_TIME_MS * CLK_KHZ;
    localparam int unsigned DISCH_CYC  = DISCH_TIME_MS * CLK_KHZ;
    localparam int unsigned SAMPLE_CYC = SAMPLE_TIME_MS * CLK_KHZ;
    localparam int unsigned TMR_W      = 20;
    localparam int unsigned FAULT_LIMIT = 3;

    // register offsets
    localparam logic [7:0] ADDR_POWER_CONFIG = 8'h1c;
    localparam logic [7:0] ADDR_CABLE_CTRL   = 8'h1d;
    localparam logic [7:0] ADDR_FAULT_CONFIG = 8'h1e;
    localparam logic [7:0] ADDR_PORT_STATUS  = 8'h1f;
    localparam logic [7:0] ADDR_VOLT_LOW     = 8'h70;
    localparam logic [7:0] ADDR_VOLT_HIGH    = 8'h71;
    localparam logic [7:0] ADDR_CURRENT      = 8'h80;

    // field positions
    localparam int unsigned POS_ADC_DISABLE  = 6;
    localparam int unsigned POS_CP_ENABLE    = 0;
    localparam int unsigned POS_CP_ORIENT    = 1;
    localparam int unsigned POS_RP_ADV       = 2;
    localparam int unsigned POS_REPORT_DIS   = 0;

    // reset values
    localparam logic [7:0] RST_POWER_CONFIG  = 8'h40;
    localparam logic [7:0] RST_CABLE_CTRL    = 8'h00;
    localparam logic [7:0] RST_FAULT_CONFIG  = 8'h00;
    // i2c target address, arbitrary default
    localparam logic [6:0] RST_I2C_ADDR      = 7'h28;

    typedef enum logic [2:0] {
        I2_IDLE, I2_ADDR, I2_ACK, I2_PTR, I2_WDATA, I2_RDATA, I2_MACK
    } tpf_i2c_state_type;

    typedef enum logic [1:0] {
        CP_OFF, CP_DIAG, CP_ON, CP_RETRY
    } tpf_cp_state_type;

    // one register access from the i2c target
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tpf_reg_req_type;
endpackage : tpf_pkg
`default_nettype wire

// ==== src/tpf_port_top.sv ====
// tpf_port_top: cable power fault retry, discharge, attach, bmc pin, bus adc
//
// Function
// - first uv fault: switch off, diag on, watch short
// - fault gone: normal soft-start again
// - later faults repeat it, counted consecutive
// - third fault: low flag, 16ms retry timer
// - retry expiry: restart, count at zero
// - low flag held while uv persists
// - report disable hides flag only
// - each disable discharges pin for 1ms
// - legacy sink termination reports attach
// - bmc drive overrides attach bias
// - bmc idle: high impedance
// - adc runs: 10-bit volt, 7-bit current
// - adc off at reset; bit 6 zero starts
// - bit 6 one stops the adc
// - each volt sample (every other tick) updates volt_r behind split regs
// - low byte read latches high bits
// - pin above short: start, diag off 500us
`default_nettype none
module tpf_port_top
    import tpf_pkg::*;
#(
    parameter logic [6:0]  I2C_ADDR   = RST_I2C_ADDR,
    parameter int unsigned DIAG_CNT   = DIAG_CYC,
    parameter int unsigned RETRY_CNT  = RETRY_CYC,
    parameter int unsigned DISCH_CNT  = DISCH_CYC,
    parameter int unsigned SAMPLE_CNT = SAMPLE_CYC,
    parameter int unsigned VOLT_W     = 10,
    parameter int unsigned CURR_W     = 7
) (
    input  wire logic              SYS_CLK_IN,
    input  wire logic              RESET_IN,
    input  wire logic              SCL_IN,
    input  wire logic              SDA_IN,
    output logic                   SDA_OUT,
    output logic                   SDA_OE_OUT,
    input  wire logic              CABLE_UV_IN,
    input  wire logic              ABOVE_SHORT_IN,
    input  wire logic              SINK_TERM_IN,
    input  wire logic [VOLT_W-1:0] ADC_VOLT_IN,
    input  wire logic [CURR_W-1:0] ADC_CURR_IN,
    input  wire logic              BMC_TX_ACTIVE_IN,
    input  wire logic              BMC_TX_BIT_IN,
    output logic [1:0]             CABLE_SWITCH_OUT,
    output logic [1:0]             DIAG_CURRENT_OUT,
    output logic [1:0]             DISCHARGE_OUT,
    output logic                   ATTACHED_OUT,
    output logic                   BMC_TX_OUT,
    output logic                   BMC_TX_OE_OUT,
    output logic                   ATTACH_BIAS_EN_OUT,
    output logic [1:0]             RP_ADV_OUT,
    output logic                   ADC_RUN_OUT
);
    ////////////////////////////////////////////////////////////////////////
    tpf_reg_req_type  req;
    logic [7:0]       rdata;
    logic [7:0]       power_config_r;
    logic [7:0]       cable_ctrl_r;
    logic [7:0]       fault_config_r;
    logic [1:0]       uv_sync_r;
    logic [1:0]       short_sync_r;
    logic [1:0]       sink_sync_r;
    logic [VOLT_W-1:0] volt_s1_r;
    logic [VOLT_W-1:0] volt_s2_r;
    logic [CURR_W-1:0] curr_s1_r;
    logic [CURR_W-1:0] curr_s2_r;
    tpf_cp_state_type cp_state_r;
    tpf_cp_state_type cp_state_nxt;
    logic [TMR_W-1:0] tmr_r;
    logic [TMR_W-1:0] tmr_nxt;
    logic [1:0]       fault_cnt_r;
    logic [1:0]       fault_cnt_nxt;
    logic             low_flag_r;
    logic             low_flag_set;
    logic             enable_d_r;
    logic [TMR_W-1:0] disch_tmr_r;
    logic             disch_ch_r;
    logic [TMR_W-1:0] sample_tmr_r;
    logic             phase_r;
    logic [VOLT_W-1:0] volt_r;
    logic [CURR_W-1:0] curr_r;
    logic [1:0]       high_latch_r;
    logic             attached_r;
    logic             bmc_bit_r;
    logic             bmc_oe_r;

    function automatic logic [1:0] chan_sel(input logic orient,
                                            input logic on);
        chan_sel = on ? (orient ? 2'b10 : 2'b01) : 2'b00;
    endfunction : chan_sel

    tpf_i2c_target #(
        .DEV_ADDR   (I2C_ADDR)
    ) u_i2c (
        .clk_in     (SYS_CLK_IN),
        .rst_in     (RESET_IN),
        .scl_in     (SCL_IN),
        .sda_in     (SDA_IN),
        .sda_oe_out (SDA_OE_OUT),
        .rdata_in   (rdata),
        .req_out    (req)
    );
    assign SDA_OUT = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // register decode
    wire wr_power = req.wr & (req.addr == ADDR_POWER_CONFIG);
    wire wr_cable = req.wr & (req.addr == ADDR_CABLE_CTRL);
    wire wr_fault = req.wr & (req.addr == ADDR_FAULT_CONFIG);
    wire rd_vlow  = req.rd & (req.addr == ADDR_VOLT_LOW);
    wire cp_enable  = cable_ctrl_r[POS_CP_ENABLE];
    wire cp_orient  = cable_ctrl_r[POS_CP_ORIENT];
    wire adc_run    = ~power_config_r[POS_ADC_DISABLE];
    wire uv_s       = uv_sync_r[1];
    wire short_ok_s = short_sync_r[1];
    wire flag_shown = low_flag_r & ~fault_config_r[POS_REPORT_DIS];
    wire [7:0] status_word = {4'h0, adc_run, cp_state_r == CP_ON,
                              attached_r, flag_shown};
    wire [7:0] volt_low_word = volt_r[7:0];
    wire [7:0] volt_high_word = {6'h00, high_latch_r};
    wire [7:0] curr_word = {{(8-CURR_W){1'b0}}, curr_r}; // top bit zero

    always_comb begin
        case (req.addr)
            ADDR_POWER_CONFIG: rdata = power_config_r;
            ADDR_CABLE_CTRL:   rdata = cable_ctrl_r;
            ADDR_FAULT_CONFIG: rdata = fault_config_r;
            ADDR_PORT_STATUS:  rdata = status_word;
            ADDR_VOLT_LOW:     rdata = volt_low_word;
            ADDR_VOLT_HIGH:    rdata = volt_high_word;
            ADDR_CURRENT:      rdata = curr_word;
            default:           rdata = 8'h00;
        endcase
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (RESET_IN) begin
            power_config_r <= RST_POWER_CONFIG; // adc off after reset
            cable_ctrl_r   <= RST_CABLE_CTRL;
            fault_config_r <= RST_FAULT_CONFIG;
        end else begin
            if (wr_power) begin
                power_config_r <= req.wdata; // bit 6 starts/stops
            end
            if (wr_cable) begin
                cable_ctrl_r <= req.wdata; // pull-up advert field
            end
            if (wr_fault) begin
                fault_config_r <= req.wdata;
            end
        end
    end

    // analog comparators are asynchronous: two flops each
    always_ff @(posedge SYS_CLK_IN) begin
        uv_sync_r    <= {uv_sync_r[0], CABLE_UV_IN};
        short_sync_r <= {short_sync_r[0], ABOVE_SHORT_IN};
        sink_sync_r  <= {sink_sync_r[0], SINK_TERM_IN};
        // converter words are held stable between samples, so a per-bit
        // sync is safe here; a moving bus would need a handshake
        volt_s1_r    <= ADC_VOLT_IN;
        volt_s2_r    <= volt_s1_r;
        curr_s1_r    <= ADC_CURR_IN;
        curr_s2_r    <= curr_s1_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // cable power fault sequencer
    wire diag_done  = (tmr_r >= TMR_W'(DIAG_CNT - 1));
    wire retry_done = (tmr_r >= TMR_W'(RETRY_CNT - 1));

    always_comb begin
        cp_state_nxt  = cp_state_r;
        tmr_nxt       = tmr_r;
        fault_cnt_nxt = fault_cnt_r;
        low_flag_set  = 1'b0;
        case (cp_state_r)
            CP_OFF: begin
                tmr_nxt       = '0;
                fault_cnt_nxt = 2'd0;
                if (cp_enable && !uv_s) begin
                    cp_state_nxt = CP_DIAG;
                end
            end
            CP_DIAG: begin
                // only a clean pin with no fault advances the check
                if (uv_s || !short_ok_s) begin
                    tmr_nxt = '0;
                end else if (diag_done) begin
                    tmr_nxt      = '0;
                    cp_state_nxt = CP_ON; // soft-start, diag off
                end else begin
                    tmr_nxt = tmr_r + 1'b1;
                end
            end
            CP_ON: begin
                if (uv_s) begin
                    tmr_nxt = '0;
                    if (fault_cnt_r == 2'(FAULT_LIMIT - 1)) begin
                        fault_cnt_nxt = 2'(FAULT_LIMIT);
                        low_flag_set  = 1'b1;
                        cp_state_nxt  = CP_RETRY;
                    end else begin
                        fault_cnt_nxt = fault_cnt_r + 2'd1;
                        cp_state_nxt  = CP_DIAG; // open and diagnose
                    end
                end else if (diag_done) begin
                    fault_cnt_nxt = 2'd0;
                end else begin
                    tmr_nxt = tmr_r + 1'b1;
                end
            end
            CP_RETRY: begin
                if (retry_done) begin
                    tmr_nxt       = '0;
                    fault_cnt_nxt = 2'd0;
                    cp_state_nxt  = CP_DIAG;
                end else begin
                    tmr_nxt = tmr_r + 1'b1;
                end
            end
            default: cp_state_nxt = CP_OFF;
        endcase
        if (!cp_enable) begin
            cp_state_nxt = CP_OFF;
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (RESET_IN) begin
            cp_state_r  <= CP_OFF;
            tmr_r       <= '0;
            fault_cnt_r <= 2'd0;
            low_flag_r  <= 1'b0;
        end else begin
            cp_state_r  <= cp_state_nxt;
            tmr_r       <= tmr_nxt;
            fault_cnt_r <= fault_cnt_nxt;
            // set beats the clear by the fault going away
            low_flag_r  <= low_flag_set | (low_flag_r & uv_s);
        end
    end

    // discharge on every disable, on the channel that cp_orient selects as enable clears
    always_ff @(posedge SYS_CLK_IN) begin
        if (RESET_IN) begin
            enable_d_r  <= 1'b0;
            disch_tmr_r <= '0;
            disch_ch_r  <= 1'b0;
        end else begin
            enable_d_r <= cp_enable;
            if (enable_d_r && !cp_enable) begin
                disch_tmr_r <= TMR_W'(DISCH_CNT);
                disch_ch_r  <= cp_orient;
            end else if (disch_tmr_r != '0) begin
                disch_tmr_r <= disch_tmr_r - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus adc: voltage and current alternate, one per sample period
    wire sample_tick = adc_run && (sample_tmr_r >= TMR_W'(SAMPLE_CNT - 1));

    always_ff @(posedge SYS_CLK_IN) begin
        if (RESET_IN) begin
            sample_tmr_r <= '0;
            phase_r      <= 1'b0;
            volt_r       <= '0;
            curr_r       <= '0;
            high_latch_r <= 2'b00;
        end else begin
            if (!adc_run || sample_tick) begin
                sample_tmr_r <= '0;
            end else begin
                sample_tmr_r <= sample_tmr_r + 1'b1; // restarts each tick, held at zero while adc off
            end
            if (sample_tick) begin
                phase_r <= ~phase_r;
                if (!phase_r) begin
                    volt_r <= volt_s2_r;
                end else begin
                    curr_r <= curr_s2_r;
                end
            end
            if (rd_vlow) begin
                high_latch_r <= volt_r[9:8];
            end
        end
    end

    // attach report and bmc pin
    always_ff @(posedge SYS_CLK_IN) begin
        if (RESET_IN) begin
            attached_r <= 1'b0;
            bmc_bit_r  <= 1'b0;
            bmc_oe_r   <= 1'b0;
        end else begin
            attached_r <= sink_sync_r[1];
            bmc_bit_r  <= BMC_TX_BIT_IN;
            bmc_oe_r   <= BMC_TX_ACTIVE_IN; // release when idle
        end
    end

    assign BMC_TX_OUT         = bmc_bit_r;
    assign BMC_TX_OE_OUT      = bmc_oe_r;
    assign ATTACH_BIAS_EN_OUT = ~bmc_oe_r;
    assign ATTACHED_OUT       = attached_r;
    assign RP_ADV_OUT         = cable_ctrl_r[POS_RP_ADV+1:POS_RP_ADV];
    assign ADC_RUN_OUT        = adc_run;
    assign CABLE_SWITCH_OUT   = chan_sel(cp_orient, cp_state_r == CP_ON);
    assign DIAG_CURRENT_OUT   = chan_sel(cp_orient, cp_state_r == CP_DIAG);
    assign DISCHARGE_OUT      = chan_sel(disch_ch_r, disch_tmr_r != '0);
endmodule : tpf_port_top
`default_nettype wire
